// file: fac_map.svh
`ifndef FAC_MAP_SVH
`define FAC_MAP_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define FAC_OFS_FILTER 8'h23
`define FAC_OFS_LOCAL 8'h24
`define FAC_OFS_REMOTE 8'h25
`define FAC_OFS_PARTID 8'h3d
`define FAC_OFS_MAKERID 8'h3e
`define FAC_OFS_PINREV 8'h3f

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define FAC_RST_FILTER 8'h5d
`define FAC_RST_LOCAL 8'h41
`define FAC_RST_REMOTE 8'h61
`define FAC_RST_PINEN 1'h1

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define FAC_FF_SPINDIS 7
`define FAC_FF_RAMP 6:5
`define FAC_FF_RATE 4:2
`define FAC_FF_FILT 0
`define FAC_TT_START 7:3
`define FAC_TT_SPAN 2:0
`define FAC_PR_PINEN 7
`define FAC_PR_REV 3:0

// -----------------------------------------------------------------
// Duty scale and span arithmetic
// -----------------------------------------------------------------
`define FAC_DUTY_FULL 8'hf0
`define FAC_DUTY_PER_5C 16'h0030
`define FAC_MIN_STEP 8'h10
`define FAC_SPAN_BASE 8'h05
`define FAC_SPAN_MAXCODE 3'h4
`define FAC_SPAN_C0 9'h005
`define FAC_SPAN_C1 9'h00a
`define FAC_SPAN_C2 9'h014
`define FAC_SPAN_C3 9'h028
`define FAC_SPAN_C4 9'h050

// -----------------------------------------------------------------
// Spin-up times in ms and clock figures
// -----------------------------------------------------------------
`define FAC_SPIN_MS0 14'd200
`define FAC_SPIN_MS1 14'd400
`define FAC_SPIN_MS2 14'd600
`define FAC_SPIN_MS3 14'd800
`define FAC_SPIN_MS4 14'd1000
`define FAC_SPIN_MS5 14'd2000
`define FAC_SPIN_MS6 14'd4000
`define FAC_SPIN_MS7 14'd8000
`define FAC_CLK_PERIOD_NS 10
`define FAC_NS_PER_MS 1000000

`endif

// file: fac_pkg.sv
package fac_pkg;

  // Register access request from the serial interface engine
  typedef struct packed {
    logic [7:0] addr;
    logic wrEn;
    logic rdEn;
    logic [7:0] wrData;
  } fac_reg_req_s;

  // Fan drive states
  typedef enum logic [0:0] {
    stRun,
    stSpin
  } fac_state_e;

endpackage

// file: fac_pwm_out.sv
`timescale 1ns/100ps
`include "fac_map.svh"

module fac_pwm_out #(
  parameter logic [7:0] FULL = `FAC_DUTY_FULL
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] duty,
  output logic pwmOut
);

  // -----------------------------------------------------------------
  // Period counter and compare
  // -----------------------------------------------------------------
  logic [7:0] cntQ; // Position in PWM period
  logic [7:0] cntD;
  wire cntWrap = (cntQ == FULL - 8'h01);

  assign cntD = cntWrap ? 8'h00 : cntQ + 8'h01;

  // Counter and registered output
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cntQ <= 8'h00;
      pwmOut <= 1'b0;
    end
    else
    begin
      cntQ <= cntD;
      pwmOut <= (cntQ < duty);
    end
  end

endmodule

// file: fac_fan_ctrl.sv
`timescale 1ns/100ps
`include "fac_map.svh"

// Notes on behaviour
// - Spin-up runs only when disable bit clear
// - Duty moves at most ramp step per cycle, except the jump to desired duty when spin-up ends
// - Three-bit measurement rate field is held
// - Bit 0 enables fan filter; bit 1 unused
// - Local temperature above start activates PWM
// - Local start plus span gives full duty
// - Remote temperature above start activates PWM
// - Remote start plus span gives full duty
// - Overtemp pin drives only when enabled
// - Low four bits report read-only revision
// - Duty stays at or above configured minimum duty once reached
// - Spin-up lasts the selected spin-up time
module fac_fan_ctrl #(
  parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] MAKER_ID = 8'ha5, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h3, // Arbitrary value
  parameter int CYCLES_PER_MS = `FAC_NS_PER_MS / `FAC_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input fac_pkg::fac_reg_req_s regReq,
  output logic [7:0] regRdData,
  input wire logic [7:0] localTemp,
  input wire logic [7:0] remoteTemp,
  input wire logic monitorTick,
  input wire logic [3:0] minDutyCode,
  input wire logic [2:0] spinCode,
  input wire logic overtempAlert,
  output logic [2:0] measRate,
  output logic fanFilterEn,
  output logic pwmOut,
  output logic overtempPinOut,
  output logic overtempPinOe
);

  // -----------------------------------------------------------------
  // Helper functions
  // -----------------------------------------------------------------
  // Duty from temperature, start code and span code
  function automatic logic [7:0] spanDuty(input logic [7:0] temp,
    input logic [4:0] thr, input logic [2:0] rc);
    logic [8:0] start;
    logic [2:0] k;
    logic [8:0] span;
    logic [8:0] over;
    logic [15:0] prod;
    start = {2'b00, thr, 2'b00};
    k = (rc > `FAC_SPAN_MAXCODE) ? `FAC_SPAN_MAXCODE : rc;
    span = {1'b0, `FAC_SPAN_BASE << k};
    over = {1'b0, temp} - start;
    prod = (16'(over) * `FAC_DUTY_PER_5C) >> k;
    if ({1'b0, temp} <= start)
      spanDuty = 8'h00;
    else if (over >= span)
      spanDuty = `FAC_DUTY_FULL;
    else
      spanDuty = prod[7:0];
  endfunction

  // Spin-up length in ms for each code
  localparam logic [13:0] SPIN_MS [8] = '{`FAC_SPIN_MS0, `FAC_SPIN_MS1,
    `FAC_SPIN_MS2, `FAC_SPIN_MS3, `FAC_SPIN_MS4, `FAC_SPIN_MS5,
    `FAC_SPIN_MS6, `FAC_SPIN_MS7};
  // Span in degrees for each range code, used by the checks
  localparam logic [8:0] SPAN_DEG [8] = '{`FAC_SPAN_C0, `FAC_SPAN_C1,
    `FAC_SPAN_C2, `FAC_SPAN_C3, `FAC_SPAN_C4,
    `FAC_SPAN_C4, `FAC_SPAN_C4, `FAC_SPAN_C4};

  // -----------------------------------------------------------------
  // Register file
  // -----------------------------------------------------------------
  logic [7:0] filterQ; // Fan filter control
  logic [7:0] localQ; // Local start and span
  logic [7:0] remoteQ; // Remote start and span
  logic pinEnQ; // Overtemp pin output enable
  logic [7:0] rdDataQ; // Registered read data

  wire hitFilter = (regReq.addr == `FAC_OFS_FILTER);
  wire hitLocal = (regReq.addr == `FAC_OFS_LOCAL);
  wire hitRemote = (regReq.addr == `FAC_OFS_REMOTE);
  wire hitPinRev = (regReq.addr == `FAC_OFS_PINREV);
  wire [7:0] pinRevWord = {pinEnQ, 3'h0, REVISION};
  wire [7:0] rdSel =
    hitFilter ? filterQ :
    hitLocal ? localQ :
    hitRemote ? remoteQ :
    (regReq.addr == `FAC_OFS_PARTID) ? PART_ID :
    (regReq.addr == `FAC_OFS_MAKERID) ? MAKER_ID :
    hitPinRev ? pinRevWord : 8'h00;

  // Writes and read capture
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      filterQ <= `FAC_RST_FILTER;
      localQ <= `FAC_RST_LOCAL;
      remoteQ <= `FAC_RST_REMOTE;
      pinEnQ <= `FAC_RST_PINEN;
      rdDataQ <= 8'h00;
    end
    else
    begin
      if (regReq.wrEn && hitFilter)
        filterQ <= regReq.wrData;
      if (regReq.wrEn && hitLocal)
        localQ <= regReq.wrData;
      if (regReq.wrEn && hitRemote)
        remoteQ <= regReq.wrData;
      if (regReq.wrEn && hitPinRev)
        pinEnQ <= regReq.wrData[`FAC_PR_PINEN];
      if (regReq.rdEn)
        rdDataQ <= rdSel;
    end
  end

  assign regRdData = rdDataQ;
  assign measRate = filterQ[`FAC_FF_RATE];
  assign fanFilterEn = filterQ[`FAC_FF_FILT];

  // -----------------------------------------------------------------
  // Target duty
  // -----------------------------------------------------------------
  // local start and local span, linear rise
  wire [7:0] localDuty = spanDuty(localTemp, localQ[`FAC_TT_START],
    localQ[`FAC_TT_SPAN]);
  wire [7:0] remoteDuty = spanDuty(remoteTemp, remoteQ[`FAC_TT_START],
    remoteQ[`FAC_TT_SPAN]);
  wire [7:0] tempDuty = (localDuty > remoteDuty) ? localDuty : remoteDuty;
  wire [7:0] minDuty = 8'(minDutyCode * `FAC_MIN_STEP);
  wire [7:0] desired = (tempDuty > minDuty) ? tempDuty : minDuty;

  // -----------------------------------------------------------------
  // Ramp and spin-up control
  // -----------------------------------------------------------------
  fac_pkg::fac_state_e stateQ; // Drive state
  fac_pkg::fac_state_e stateD;
  logic [7:0] dutyQ; // Ramped duty
  logic [7:0] dutyD;
  logic [31:0] msCntQ; // Cycles within current ms
  logic [13:0] msLeftQ; // Spin-up ms remaining

  wire [7:0] stepSize = 8'h01 << filterQ[`FAC_FF_RAMP];
  wire spinDis = filterQ[`FAC_FF_SPINDIS];
  wire startReq = (dutyQ == 8'h00) && (desired != 8'h00);
  wire spinGo = (stateQ == fac_pkg::stRun) && startReq && !spinDis;
  wire msTick = (msCntQ == 32'(CYCLES_PER_MS - 1));
  wire spinDone = (stateQ == fac_pkg::stSpin) && msTick &&
    (msLeftQ == 14'd1);
  wire [7:0] upDiff = desired - dutyQ;
  wire [7:0] downDiff = dutyQ - desired;

  // Next state and next duty
  always_comb
  begin
    stateD = stateQ;
    dutyD = dutyQ;
    unique case (stateQ)
      fac_pkg::stRun:
      begin
        if (spinGo)
          stateD = fac_pkg::stSpin;
        else if (monitorTick && desired > dutyQ)
          dutyD = (upDiff > stepSize) ? dutyQ + stepSize : desired;
        else if (monitorTick && desired < dutyQ)
          dutyD = (downDiff > stepSize) ? dutyQ - stepSize : desired;
      end
      fac_pkg::stSpin:
      begin
        // Hand over at the requested duty
        if (spinDone)
        begin
          stateD = fac_pkg::stRun;
          dutyD = desired;
        end
      end
    endcase
  end

  // State, duty and spin-up timer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stateQ <= fac_pkg::stRun;
      dutyQ <= 8'h00;
      msCntQ <= 32'h0;
      msLeftQ <= 14'h0;
    end
    else
    begin
      stateQ <= stateD;
      dutyQ <= dutyD;
      if (spinGo)
      begin
        msCntQ <= 32'h0;
        msLeftQ <= SPIN_MS[spinCode];
      end
      else if (stateQ == fac_pkg::stSpin)
      begin
        msCntQ <= msTick ? 32'h0 : msCntQ + 32'h1;
        if (msTick)
          msLeftQ <= msLeftQ - 14'd1;
      end
    end
  end

  wire [7:0] appliedDuty = (stateQ == fac_pkg::stSpin) ?
    `FAC_DUTY_FULL : dutyQ;

  fac_pwm_out #(
    .FULL(`FAC_DUTY_FULL)
  ) fac_pwm_out_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .duty(appliedDuty),
    .pwmOut(pwmOut)
  );

  // -----------------------------------------------------------------
  // Overtemp pin
  // -----------------------------------------------------------------
  // open-drain low only while enabled
  assign overtempPinOut = 1'b0;
  assign overtempPinOe = pinEnQ && overtempAlert;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] prevDutyQ; // Duty one cycle back
  always_ff @(posedge core_clk)
  begin
    prevDutyQ <= dutyQ;
  end
  wire [7:0] dutyMove = (dutyQ > prevDutyQ) ? dutyQ - prevDutyQ :
    prevDutyQ - dutyQ;
  chk_spin_skip: assert property (
    (stateQ == fac_pkg::stRun && startReq && spinDis) |=>
      stateQ == fac_pkg::stRun)
    else $error("spin-up ran while disabled");
  chk_ramp_bound: assert property (
    (stateQ == fac_pkg::stRun && !spinGo) |=>
      dutyMove <= $past(stepSize))
    else $error("duty moved beyond ramp step");
  chk_rate_field: assert property (
    (regReq.wrEn && hitFilter) |=> measRate == $past(regReq.wrData[4:2]))
    else $error("rate field not stored");
  chk_filter_enable: assert property (
    (regReq.wrEn && hitFilter) |=> fanFilterEn == $past(regReq.wrData[0]))
    else $error("filter enable not stored");
  chk_local_active: assert property (
    ({1'b0, localTemp} > {2'b00, localQ[7:3], 2'b00}) |-> localDuty != 8'h00)
    else $error("local start did not activate");
  chk_local_full: assert property (
    ({1'b0, localTemp} >= {2'b00, localQ[`FAC_TT_START], 2'b00} +
      SPAN_DEG[localQ[`FAC_TT_SPAN]]) |-> localDuty == `FAC_DUTY_FULL)
    else $error("local span did not give full duty");
  chk_remote_active: assert property (
    ({1'b0, remoteTemp} > {2'b00, remoteQ[7:3], 2'b00}) |->
      remoteDuty != 8'h00)
    else $error("remote start did not activate");
  chk_remote_full: assert property (
    ({1'b0, remoteTemp} >= {2'b00, remoteQ[`FAC_TT_START], 2'b00} +
      SPAN_DEG[remoteQ[`FAC_TT_SPAN]]) |-> remoteDuty == `FAC_DUTY_FULL)
    else $error("remote span did not give full duty");
  chk_pin_gate: assert property (
    !pinEnQ |-> !overtempPinOe)
    else $error("overtemp pin driven while disabled");
  chk_rev_readonly: assert property (
    (regReq.rdEn && hitPinRev) |=> regRdData[3:0] == REVISION)
    else $error("revision field changed");
  chk_min_floor: assert property (
    (dutyQ >= minDuty) |=> (dutyQ >= minDuty || $changed(minDutyCode)))
    else $error("duty fell below minimum duty");
  chk_spin_hold: assert property (
    spinGo |=> (stateQ == fac_pkg::stSpin && appliedDuty == `FAC_DUTY_FULL)[*2])
    else $error("spin-up ended early");

  cov_spin: cover property (spinGo ##1 stateQ == fac_pkg::stSpin);
  cov_full: cover property (stateQ == fac_pkg::stRun &&
    dutyQ == `FAC_DUTY_FULL);
  cov_pin: cover property (overtempPinOe);
endmodule

// file: fac_fan_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Fan model: the duty the fan really sees
// ----------------------------------------
module fac_fan_model (
  input wire logic core_clk,
  input wire logic pwmOut,
  output logic [8:0] measDuty
);
  logic [7:0] winQ; // Place in window
  logic [8:0] accQ; // Driven cycles so far
  initial
  begin
    winQ = 8'h00;
    accQ = 9'h000;
    measDuty = 9'h000;
  end
  // Count drive over each 240-cycle window
  always @(posedge core_clk)
  begin
    if (winQ == 8'hef)
    begin
      measDuty <= accQ + {8'h00, pwmOut};
      accQ <= 9'h000;
      winQ <= 8'h00;
    end
    else
    begin
      accQ <= accQ + {8'h00, pwmOut};
      winQ <= winQ + 8'h01;
    end
  end
endmodule

// file: fac_fan_ctrl_tb.sv
`timescale 1ns/100ps
module fac_fan_ctrl_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  fac_pkg::fac_reg_req_s regReq = '0;
  logic [7:0] localTemp = 8'h00;
  logic [7:0] remoteTemp = 8'h00;
  logic monitorTick = 1'b0;
  logic [3:0] minDutyCode = 4'h0;
  logic [2:0] spinCode = 3'h0;
  logic overtempAlert = 1'b0;
  logic [7:0] regRdData;
  logic [2:0] measRate;
  logic fanFilterEn;
  logic pwmOut;
  logic overtempPinOut;
  logic overtempPinOe;
  logic [8:0] measDuty;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  // Ids are arbitrary values
  fac_fan_ctrl #(.PART_ID(8'h12), .MAKER_ID(8'h34), .REVISION(4'h3),
    .CYCLES_PER_MS(4)) fac_fan_ctrl_inst (.core_clk(core_clk),
    .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
    .localTemp(localTemp), .remoteTemp(remoteTemp),
    .monitorTick(monitorTick), .minDutyCode(minDutyCode),
    .spinCode(spinCode), .overtempAlert(overtempAlert),
    .measRate(measRate), .fanFilterEn(fanFilterEn), .pwmOut(pwmOut),
    .overtempPinOut(overtempPinOut), .overtempPinOe(overtempPinOe));
  fac_fan_model fac_fan_model_inst (.core_clk(core_clk), .pwmOut(pwmOut),
    .measDuty(measDuty));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp,
    input string what);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic do_reset;
    @(negedge core_clk);
    rst_n = 1'b0;
    localTemp = 8'h00;
    remoteTemp = 8'h00;
    minDutyCode = 4'h0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regReq.addr = a;
    regReq.wrData = d;
    regReq.wrEn = 1'b1;
    @(negedge core_clk);
    regReq.wrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    regReq.addr = a;
    regReq.rdEn = 1'b1;
    @(negedge core_clk);
    regReq.rdEn = 1'b0;
    check({1'b0, regRdData}, {1'b0, exp}, "read data");
  endtask
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(negedge core_clk);
      monitorTick = 1'b1;
      @(negedge core_clk);
      monitorTick = 1'b0;
    end
  endtask
  task automatic duty(input int w, input logic [8:0] exp);
    repeat (w) @(negedge core_clk);
    check(measDuty, exp, "fan duty");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // reset values, access kinds
  task automatic t_regs;
    do_reset();
    rd(8'h23, 8'h5d);
    rd(8'h24, 8'h41);
    rd(8'h25, 8'h61);
    rd(8'h3f, 8'h83);
    rd(8'h3d, 8'h12);
    rd(8'h3e, 8'h34);
    rd(8'h30, 8'h00);
    wr(8'h3d, 8'hff);
    rd(8'h3d, 8'h12);
    wr(8'h3f, 8'h0f);
    rd(8'h3f, 8'h03);
    wr(8'h23, 8'h81);
    check({6'h00, measRate}, 9'h000, "rate");
    check({8'h00, fanFilterEn}, 9'h001, "filter");
    wr(8'h23, 8'h9c);
    check({6'h00, measRate}, 9'h007, "rate");
    check({8'h00, fanFilterEn}, 9'h000, "filter");
  endtask
  task automatic t_pin;
    do_reset();
    overtempAlert = 1'b1;
    @(negedge core_clk);
    check({8'h00, overtempPinOe}, 9'h001, "pin enable");
    check({8'h00, overtempPinOut}, 9'h000, "pin level");
    wr(8'h3f, 8'h00);
    check({8'h00, overtempPinOe}, 9'h000, "pin enable");
    wr(8'h3f, 8'h80);
    check({8'h00, overtempPinOe}, 9'h001, "pin enable");
    overtempAlert = 1'b0;
  endtask
  task automatic t_ramp;
    for (int c = 0; c < 4; c++)
    begin
      do_reset();
      wr(8'h23, {1'b1, c[1:0], 5'h00});
      localTemp = 8'd42;
      duty(520, 9'h000);
      ticks(3);
      duty(520, 9'd3 << c);
    end
  endtask
  task automatic t_span;
    do_reset();
    wr(8'h23, 8'he0);
    localTemp = 8'd37;
    ticks(30);
    duty(520, 9'd120);
    localTemp = 8'd32;
    ticks(30);
    duty(520, 9'd0);
    localTemp = 8'd0;
    wr(8'h25, 8'h60);
    remoteTemp = 8'd50;
    ticks(30);
    duty(520, 9'd96);
    remoteTemp = 8'd53;
    ticks(30);
    duty(520, 9'd240);
  endtask
  task automatic t_min;
    do_reset();
    wr(8'h23, 8'he0);
    minDutyCode = 4'h3;
    ticks(10);
    duty(520, 9'd48);
  endtask
  task automatic t_spin;
    do_reset();
    spinCode = 3'h0;
    localTemp = 8'd37;
    duty(500, 9'd240);
    duty(900, 9'd120);
    do_reset();
    spinCode = 3'h1;
    localTemp = 8'd37;
    duty(1100, 9'd240);
    duty(1000, 9'd120);
  endtask
  initial
  begin
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    t_regs();
    t_pin();
    t_ramp();
    t_span();
    t_min();
    t_spin();
    close_out();
  end
endmodule
